//--- tecr_regs.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "tecr_params.svh"
module tecr_regs
  import tecr_pkg::*;
#(
  parameter int CNT_W = 3,
  parameter int TMR_W = 11
)
(
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic measure_start,
  input tecr_echo_t echo_in,
  input logic [2:0] echo_threshold_select,
  input logic [CNT_W-1:0] expected_rx_count,
  input logic second_mode,
  output logic error_out_n,
  output logic base_period_tick,
  output tecr_seq_t seq_status
);

//////////////////////////////////////////////////////////////////////////////
// state

  logic short_flight_force;
  logic [2:0] short_flight_blanking;
  logic echo_timeout_off;
  logic [1:0] listening_window_select;
  logic input_clock_halving;
  logic [1:0] receiver_offset_cancel_period;
  logic next_short_flight_force;
  logic [2:0] next_short_flight_blanking;
  logic next_echo_timeout_off;
  logic [1:0] next_listening_window_select;
  logic next_input_clock_halving;
  logic [1:0] next_receiver_offset_cancel_period;

  logic weak_signal_flag;
  logic no_signal_flag;
  logic signal_too_high_flag;
  logic next_weak_signal_flag;
  logic next_no_signal_flag;
  logic next_signal_too_high_flag;
  logic next_error_out_n;

  tecr_state_t state;
  tecr_state_t next_state;
  logic [CNT_W-1:0] rx_count;
  logic [CNT_W-1:0] next_rx_count;
  tecr_seq_t next_seq_status;

  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  logic tick;
  logic timer_done;
  logic timer_restart;
  logic [TMR_W-1:0] timer_limit;
  logic next_base_period_tick;

//////////////////////////////////////////////////////////////////////////////
// bus decode

  logic [`TECR_IDX_W-1:0] idx;
  logic lane_ok;
  logic sel_err;
  logic sel_to;
  logic sel_ck;
  logic mapped;
  logic wr;
  logic clear_all;
  logic abort;
  logic timeout_now;
  logic set_weak;
  logic set_none;
  logic set_high;

  assign idx = paddr[11:2];
  assign lane_ok = (paddr[1:0] == `TECR_LANE_OK);
  assign sel_err = lane_ok & (idx == `TECR_IDX_ERR);
  assign sel_to = lane_ok & (idx == `TECR_IDX_TIMEOUT);
  assign sel_ck = lane_ok & (idx == `TECR_IDX_CLOCK);
  assign mapped = sel_err | sel_to | sel_ck;
  assign wr = psel & penable & pready & pwrite & mapped;
  assign clear_all = wr & sel_err & pwdata[`TECR_ERR_HIGH_BIT];
  assign abort = wr & sel_err & pwdata[`TECR_ERR_NONE_BIT];

//////////////////////////////////////////////////////////////////////////////
// configuration registers

  always_comb begin
    next_short_flight_force = short_flight_force;
    next_short_flight_blanking = short_flight_blanking;
    next_echo_timeout_off = echo_timeout_off;
    next_listening_window_select = listening_window_select;
    next_input_clock_halving = input_clock_halving;
    next_receiver_offset_cancel_period = receiver_offset_cancel_period;
    // reserved bits are not stored
    if (wr & sel_to) begin
      next_short_flight_force = pwdata[`TECR_TO_FORCE_BIT];
      next_short_flight_blanking = pwdata[`TECR_TO_BLANK_MSB:`TECR_TO_BLANK_LSB];
      next_echo_timeout_off = pwdata[`TECR_TO_OFF_BIT];
      next_listening_window_select = pwdata[`TECR_TO_WIN_MSB:`TECR_TO_WIN_LSB];
    end
    if (wr & sel_ck) begin
      next_input_clock_halving = pwdata[`TECR_CK_HALVE_BIT];
      next_receiver_offset_cancel_period = pwdata[`TECR_CK_AZ_MSB:`TECR_CK_AZ_LSB];
    end
  end

  localparam logic [7:0] TO_RST = `TECR_RST_TIMEOUT;
  localparam logic [7:0] CK_RST = `TECR_RST_CLOCK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_flight_force <= TO_RST[`TECR_TO_FORCE_BIT];
      short_flight_blanking <= TO_RST[`TECR_TO_BLANK_MSB:`TECR_TO_BLANK_LSB];
      echo_timeout_off <= TO_RST[`TECR_TO_OFF_BIT];
      listening_window_select <= TO_RST[`TECR_TO_WIN_MSB:`TECR_TO_WIN_LSB];
      input_clock_halving <= CK_RST[`TECR_CK_HALVE_BIT];
      receiver_offset_cancel_period <= CK_RST[`TECR_CK_AZ_MSB:`TECR_CK_AZ_LSB];
    end else begin
      short_flight_force <= next_short_flight_force;
      short_flight_blanking <= next_short_flight_blanking;
      echo_timeout_off <= next_echo_timeout_off;
      listening_window_select <= next_listening_window_select;
      input_clock_halving <= next_input_clock_halving;
      receiver_offset_cancel_period <= next_receiver_offset_cancel_period;
    end
  end

//////////////////////////////////////////////////////////////////////////////
// base period and period timer

  tecr_base_tick u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .input_clock_halving(input_clock_halving),
    .tick(tick)
  );

  tecr_period_timer #(.TMR_W(TMR_W)) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .base_tick(tick),
    .restart(timer_restart),
    .limit(timer_limit),
    .done(timer_done)
  );

  always_comb begin
    timer_limit = '0;
    unique case (state)
      TECR_IDLE: timer_limit = '0;
      TECR_AUTOZERO: timer_limit = TMR_W'(`TECR_AZ_BASE << receiver_offset_cancel_period);
      TECR_BLANK: timer_limit = TMR_W'(`TECR_BLANK_BASE << short_flight_blanking);
      TECR_LISTEN: timer_limit = TMR_W'(`TECR_WIN_BASE << listening_window_select);
    endcase
  end

  assign timer_restart = (next_state != state);
  assign timeout_now = (state == TECR_LISTEN) & timer_done & ~echo_timeout_off;

//////////////////////////////////////////////////////////////////////////////
// measurement sequence

  always_comb begin
    next_state = state;
    unique case (state)
      TECR_IDLE: begin
        if (measure_start) next_state = TECR_AUTOZERO;
      end
      TECR_AUTOZERO: begin
        if (timer_done) next_state = short_flight_force ? TECR_BLANK : TECR_LISTEN;
      end
      TECR_BLANK: begin
        if (timer_done) next_state = TECR_LISTEN;
      end
      TECR_LISTEN: begin
        if (timeout_now) next_state = TECR_IDLE;
        else if (expected_rx_count != '0 && rx_count >= expected_rx_count) next_state = TECR_IDLE;
      end
    endcase
    if (abort) next_state = TECR_IDLE;
  end

  always_comb begin
    next_rx_count = rx_count;
    if (state == TECR_IDLE) begin
      next_rx_count = '0;
    end else if (state == TECR_LISTEN && echo_in.zero_cross && rx_count != '1) begin
      next_rx_count = rx_count + 1'b1;
    end
  end

  always_comb begin
    next_seq_status.autozero = (next_state == TECR_AUTOZERO);
    next_seq_status.blanking = (next_state == TECR_BLANK);
    next_seq_status.listening = (next_state == TECR_LISTEN);
    next_seq_status.short_flight = short_flight_force & (next_state != TECR_IDLE);
    next_seq_status.timeout = timeout_now;
    next_seq_status.abort = abort;
    next_seq_status.avg_chan_reset = abort & second_mode;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= TECR_IDLE;
      rx_count <= '0;
      seq_status <= '0;
      base_period_tick <= 1'b0;
    end else begin
      state <= next_state;
      rx_count <= next_rx_count;
      seq_status <= next_seq_status;
      base_period_tick <= next_base_period_tick;
    end
  end

  assign next_base_period_tick = tick;

//////////////////////////////////////////////////////////////////////////////
// error flags, set wins over clear

  assign set_none = timeout_now & (rx_count == '0);
  assign set_weak = timeout_now & (rx_count != '0) & (rx_count < expected_rx_count);
  assign set_high = echo_in.over_max & (echo_threshold_select == `TECR_THLD_MAX);

  always_comb begin
    next_weak_signal_flag = set_weak | (weak_signal_flag & ~clear_all);
    next_no_signal_flag = set_none | (no_signal_flag & ~(clear_all | abort));
    next_signal_too_high_flag = set_high | (signal_too_high_flag & ~clear_all);
    next_error_out_n = ~(next_weak_signal_flag | next_no_signal_flag
                         | next_signal_too_high_flag);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      weak_signal_flag <= 1'b0;
      no_signal_flag <= 1'b0;
      signal_too_high_flag <= 1'b0;
      error_out_n <= 1'b1;
    end else begin
      weak_signal_flag <= next_weak_signal_flag;
      no_signal_flag <= next_no_signal_flag;
      signal_too_high_flag <= next_signal_too_high_flag;
      error_out_n <= next_error_out_n;
    end
  end

//////////////////////////////////////////////////////////////////////////////
// apb answer, one wait state

  always_comb begin
    next_pready = psel & penable & ~pready;
    next_pslverr = psel & penable & ~pready & ~mapped;
    next_prdata = '0;
    if (sel_err) begin
      next_prdata[`TECR_ERR_WEAK_BIT] = weak_signal_flag;
      next_prdata[`TECR_ERR_NONE_BIT] = no_signal_flag;
      next_prdata[`TECR_ERR_HIGH_BIT] = signal_too_high_flag;
    end
    if (sel_to) begin
      next_prdata[`TECR_TO_FORCE_BIT] = short_flight_force;
      next_prdata[`TECR_TO_BLANK_MSB:`TECR_TO_BLANK_LSB] = short_flight_blanking;
      next_prdata[`TECR_TO_OFF_BIT] = echo_timeout_off;
      next_prdata[`TECR_TO_WIN_MSB:`TECR_TO_WIN_LSB] = listening_window_select;
    end
    if (sel_ck) begin
      next_prdata[`TECR_CK_HALVE_BIT] = input_clock_halving;
      next_prdata[`TECR_CK_AZ_MSB:`TECR_CK_AZ_LSB] = receiver_offset_cancel_period;
    end
    if (!(psel & penable & ~pready & ~pwrite)) next_prdata = '0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

//////////////////////////////////////////////////////////////////////////////
// checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_weak_set;
    timeout_now && rx_count != '0 && rx_count < expected_rx_count |=> weak_signal_flag;
  endproperty
  a_weak_set: assert property (p_weak_set) else $error("weak flag not set");

  property p_none_set;
    timeout_now && rx_count == '0 |=> no_signal_flag && !error_out_n;
  endproperty
  a_none_set: assert property (p_none_set) else $error("no-signal flag not set");

  property p_abort;
    abort |=> state == TECR_IDLE && seq_status.abort
              && seq_status.avg_chan_reset == $past(second_mode);
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not idle");

  property p_high_gated;
    !signal_too_high_flag && echo_threshold_select != `TECR_THLD_MAX |=> !signal_too_high_flag;
  endproperty
  a_high_gated: assert property (p_high_gated) else $error("high flag ungated");

  property p_clear_all;
    clear_all && !set_weak && !set_none && !set_high
      |=> !weak_signal_flag && !no_signal_flag && !signal_too_high_flag && error_out_n;
  endproperty
  a_clear_all: assert property (p_clear_all) else $error("flags not cleared");

  property p_blank_path;
    state == TECR_AUTOZERO && timer_done && !abort
      |=> state == (short_flight_force ? TECR_BLANK : TECR_LISTEN);
  endproperty
  a_blank_path: assert property (p_blank_path) else $error("short flight path wrong");

  property p_no_timeout;
    echo_timeout_off |-> !timeout_now;
  endproperty
  a_no_timeout: assert property (p_no_timeout) else $error("timeout while off");

  property p_halving;
    input_clock_halving && $past(input_clock_halving) && base_period_tick |=> !base_period_tick;
  endproperty
  a_halving: assert property (p_halving) else $error("base period not halved");

  property p_pin;
    $rose(weak_signal_flag || no_signal_flag || signal_too_high_flag) |-> !error_out_n;
  endproperty
  a_pin: assert property (p_pin) else $error("error pin not low");

  property p_reserved;
    pready |-> prdata[31:8] == '0 && !(sel_err && prdata[7:3] != '0);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

endmodule : tecr_regs

//--- tecr_params.svh
`ifndef TECR_PARAMS_SVH
`define TECR_PARAMS_SVH

// register indexes, byte address is four times the index
`define TECR_IDX_W 10
`define TECR_IDX_ERR 10'h007
`define TECR_IDX_TIMEOUT 10'h008
`define TECR_IDX_CLOCK 10'h009
`define TECR_LANE_OK 2'h0

// reset values
`define TECR_RST_TIMEOUT 8'h19
`define TECR_RST_CLOCK 8'h00

// error status fields
`define TECR_ERR_WEAK_BIT 2
`define TECR_ERR_NONE_BIT 1
`define TECR_ERR_HIGH_BIT 0

// echo timeout config fields
`define TECR_TO_FORCE_BIT 6
`define TECR_TO_BLANK_MSB 5
`define TECR_TO_BLANK_LSB 3
`define TECR_TO_OFF_BIT 2
`define TECR_TO_WIN_MSB 1
`define TECR_TO_WIN_LSB 0

// clock rate config fields
`define TECR_CK_HALVE_BIT 2
`define TECR_CK_AZ_MSB 1
`define TECR_CK_AZ_LSB 0

// period bases in base periods, scaled by two to the code
`define TECR_BLANK_BASE 11'h008
`define TECR_WIN_BASE 11'h080
`define TECR_AZ_BASE 11'h040

// largest echo qualification threshold code
`define TECR_THLD_MAX 3'h7

`endif

//--- tecr_pkg.sv
package tecr_pkg;

  typedef enum logic [1:0] {
    TECR_IDLE,
    TECR_AUTOZERO,
    TECR_BLANK,
    TECR_LISTEN
  } tecr_state_t;

  // echo events from the receive path
  typedef struct packed {
    logic zero_cross;
    logic over_max;
  } tecr_echo_t;

  // measurement sequence status towards the rest of the device
  typedef struct packed {
    logic autozero;
    logic blanking;
    logic listening;
    logic short_flight;
    logic timeout;
    logic abort;
    logic avg_chan_reset;
  } tecr_seq_t;

endpackage : tecr_pkg

//--- tecr_base_tick.sv
`timescale 1ns/1ps
module tecr_base_tick
  import tecr_pkg::*;
(
  input logic pclk,
  input logic presetn,
  input logic input_clock_halving,
  output logic tick
);

  logic phase;
  logic next_phase;

  always_comb begin
    next_phase = input_clock_halving ? ~phase : 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 1'b0;
    end else begin
      phase <= next_phase;
    end
  end

  // divide by one or two
  assign tick = ~input_clock_halving | phase;

endmodule : tecr_base_tick

//--- tecr_period_timer.sv
`timescale 1ns/1ps
module tecr_period_timer
  import tecr_pkg::*;
#(
  parameter int TMR_W = 11
)
(
  input logic pclk,
  input logic presetn,
  input logic base_tick,
  input logic restart,
  input logic [TMR_W-1:0] limit,
  output logic done
);

  logic [TMR_W-1:0] count;
  logic [TMR_W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (restart) begin
      next_count = '0;
    end else if (base_tick) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // last base period of the programmed length
  assign done = base_tick & (count == limit - 1'b1);

endmodule : tecr_period_timer

//--- tecr_host_model.sv
`timescale 1ns/1ps
`include "tecr_params.svh"
module tecr_host_model
  import tecr_pkg::*;
(
  input logic pclk,
  input logic presetn,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr
);
  localparam logic [11:0] ERR_ADDR = {`TECR_IDX_ERR, 2'b00};

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // one apb transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  //////////////////////////////////////////////////////////////////////////////
  // status read and flag clear ahead of every measurement
  task automatic prepare();
    logic [31:0] rd;
    logic e;
    xfer(1'b0, ERR_ADDR, 32'h0, rd, e);
    if (rd[2:0] !== 3'h0) xfer(1'b1, ERR_ADDR, 32'h1, rd, e);
  endtask : prepare
endmodule : tecr_host_model

//--- tb_tof_error_timeout_clock_regs.sv
`timescale 1ns/1ps
`include "tecr_params.svh"
module tb_tof_error_timeout_clock_regs
  import tecr_pkg::*;
;
  localparam logic [11:0] A_ERR = {`TECR_IDX_ERR, 2'b00};
  localparam logic [11:0] A_TO = {`TECR_IDX_TIMEOUT, 2'b00};
  localparam logic [11:0] A_CK = {`TECR_IDX_CLOCK, 2'b00};
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, measure_start, second_mode;
  logic error_out_n, base_period_tick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] echo_threshold_select, expected_rx_count;
  tecr_echo_t echo_in;
  tecr_seq_t seq_status;
  int err_count, check_count, cyc, az_len, bl_len, li_len, tk_len;
  logic sf_seen, to_seen, ab_seen, avg_seen;

  always #2.5 pclk = ~pclk;

  tecr_host_model i_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  tecr_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .measure_start(measure_start), .echo_in(echo_in),
    .echo_threshold_select(echo_threshold_select), .expected_rx_count(expected_rx_count),
    .second_mode(second_mode), .error_out_n(error_out_n),
    .base_period_tick(base_period_tick), .seq_status(seq_status));

  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] fit(input int seen, input int exp);
    return ((seen >= exp - 3) && (seen <= exp + 3)) ? exp : seen;
  endfunction : fit

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    i_host.xfer(1'b1, a, d, rd, e);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic e;
    i_host.xfer(1'b0, a, 32'h0, rd, e);
    check(rd, exp);
  endtask : rd_chk

  task automatic start_meas(input logic [7:0] to_cfg, input logic [7:0] ck_cfg);
    wr(A_TO, {24'h0, to_cfg});
    wr(A_CK, {24'h0, ck_cfg});
    i_host.prepare();
    {az_len, bl_len, li_len} = '0;
    {sf_seen, to_seen, ab_seen, avg_seen} = 4'h0;
    @(posedge pclk);
    measure_start <= 1'b1;
    @(posedge pclk);
    measure_start <= 1'b0;
    while (seq_status.listening !== 1'b1) @(posedge pclk);
  endtask : start_meas

  task automatic finish_meas(input int crossings);
    repeat (crossings) begin
      @(posedge pclk);
      echo_in.zero_cross <= 1'b1;
      @(posedge pclk);
      echo_in.zero_cross <= 1'b0;
    end
    while (seq_status[6:3] !== 4'h0) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask : finish_meas

  task automatic over_range(input logic [2:0] thr);
    echo_threshold_select <= thr;
    @(posedge pclk);
    echo_in.over_max <= 1'b1;
    @(posedge pclk);
    echo_in.over_max <= 1'b0;
  endtask : over_range

  //////////////////////////////////////////////////////////////////////////////
  // phase lengths, event capture and watchdog
  always @(posedge pclk) begin
    cyc++;
    if (seq_status.autozero === 1'b1) az_len++;
    if (seq_status.blanking === 1'b1) bl_len++;
    if (seq_status.listening === 1'b1) li_len++;
    if (base_period_tick === 1'b1) tk_len++;
    if (seq_status.short_flight === 1'b1) sf_seen = 1'b1;
    if (seq_status.timeout === 1'b1) to_seen = 1'b1;
    if (seq_status.abort === 1'b1) ab_seen = 1'b1;
    if (seq_status.avg_chan_reset === 1'b1) avg_seen = 1'b1;
    if (cyc == 60000) begin
      err_count++;
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] rd;
    logic e;
    int per, e_az, e_bl, e_li;
    {presetn, measure_start, second_mode} = 3'h0;
    echo_in = '0;
    echo_threshold_select = 3'h0;
    expected_rx_count = 3'h0;
    {err_count, check_count, cyc} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(A_TO, 32'h19);
    rd_chk(A_CK, 32'h0);
    rd_chk(A_ERR, 32'h0);
    check({31'h0, error_out_n}, 32'h1);
    wr(A_TO, 32'hFF);
    rd_chk(A_TO, 32'h7F);
    wr(A_CK, 32'hFF);
    rd_chk(A_CK, 32'h7);
    wr(A_ERR, 32'hF8);
    rd_chk(A_ERR, 32'h0);
    i_host.xfer(1'b0, 12'h030, 32'h0, rd, e);
    check({rd[30:0], e}, 32'h1);
    // every window and auto-zero code, every blanking code but 5 (short flight off there), with and without halving
    for (int i = 0; i < 8; i++) begin
      per = (i > 5) ? 2 : 1;
      e_az = (64 << ((i + 1) % 4)) * per;
      e_bl = (i != 5) ? (8 << i) * per : 0;
      e_li = (128 << (i % 4)) * per;
      start_meas({1'b0, (i != 5), i[2:0], 1'b0, i[1:0]}, {5'h0, (i > 5), 2'(i + 1)});
      finish_meas(0);
      check(fit(az_len, e_az), e_az);
      check(fit(bl_len, e_bl), e_bl);
      check(fit(li_len, e_li), e_li);
      check({31'h0, sf_seen}, {31'h0, (i != 5)});
      check({31'h0, to_seen}, 32'h1);
      rd_chk(A_ERR, 32'h2);
      check({31'h0, error_out_n}, 32'h0);
      wr(A_ERR, 32'h2);
      rd_chk(A_ERR, 32'h0);
      check({31'h0, error_out_n}, 32'h1);
    end
    // halving still on from the last pass: one base period every other cycle
    tk_len = 0;
    repeat (100) @(posedge pclk);
    check(fit(tk_len, 50), 50);
    // too few crossings, then enough crossings
    expected_rx_count <= 3'h3;
    start_meas(8'h00, 8'h00);
    finish_meas(1);
    rd_chk(A_ERR, 32'h4);
    i_host.prepare();
    rd_chk(A_ERR, 32'h0);
    start_meas(8'h00, 8'h00);
    finish_meas(3);
    rd_chk(A_ERR, 32'h0);
    check({31'h0, to_seen}, 32'h0);
    // over-range only counts at the top threshold; one write clears all
    expected_rx_count <= 3'h0;
    start_meas(8'h00, 8'h00);
    finish_meas(0);
    over_range(3'h6);
    rd_chk(A_ERR, 32'h2);
    over_range(3'h7);
    rd_chk(A_ERR, 32'h3);
    check({31'h0, error_out_n}, 32'h0);
    wr(A_ERR, 32'h1);
    rd_chk(A_ERR, 32'h0);
    check({31'h0, error_out_n}, 32'h1);
    // timeout disabled, then abort in mode two
    second_mode <= 1'b1;
    start_meas(8'h04, 8'h00);
    repeat (400) @(posedge pclk);
    check({31'h0, seq_status.listening}, 32'h1);
    check({31'h0, to_seen}, 32'h0);
    wr(A_ERR, 32'h2);
    repeat (3) @(posedge pclk);
    check({28'h0, seq_status[6:3]}, 32'h0);
    check({30'h0, ab_seen, avg_seen}, 32'h3);
    // halving off: a base period every cycle
    tk_len = 0;
    repeat (100) @(posedge pclk);
    check(fit(tk_len, 100), 100);
    complete_run();
  end
endmodule : tb_tof_error_timeout_clock_regs
